/* logic/gdc_map.svh */
`ifndef GDC_MAP_SVH
`define GDC_MAP_SVH

// Clock rate in kHz and timing figures in their own units
`define GDC_CLK_KHZ          100000
`define GDC_RESTART_WAIT_MS  2000
`define GDC_SHDN_PULSE_NS    3000
`define GDC_FAULT_SETTLE_NS  300

// Derived cycle counts (least times, rounded up)
`define GDC_RESTART_CYC  ((`GDC_RESTART_WAIT_MS * `GDC_CLK_KHZ))
`define GDC_SHDN_CYC     ((`GDC_SHDN_PULSE_NS * (`GDC_CLK_KHZ / 1000) + 999) / 1000)
`define GDC_SETTLE_CYC   ((`GDC_FAULT_SETTLE_NS * (`GDC_CLK_KHZ / 1000) + 999) / 1000)

// Dead time default in cycles
`define GDC_DEAD_CYC     100

// Phase indices
`define GDC_PH_U  0
`define GDC_PH_V  1
`define GDC_PH_W  2

`endif

/* logic/gdc_pkg.sv */
package gdc_pkg;

  typedef enum logic [1:0] {
    GDC_RUN     = 2'b00,
    GDC_TRIPPED = 2'b01,
    GDC_WAIT    = 2'b10,
    GDC_SHDN    = 2'b11
  } gdc_state_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } gdc_cmd_t;

  typedef struct packed {
    logic fault_in;
    logic fault_out;
    logic fault_oe;
  } gdc_od_t;

endpackage

/* logic/gdc_dead_time.sv */
`timescale 1ns/10ps
`include "gdc_map.svh"

// One phase: dead time between high and low side commands
module gdc_dead_time
  import gdc_pkg::*;
#(
  parameter int DEAD_CYC = `GDC_DEAD_CYC
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     enable,
  input  wire gdc_cmd_t want,
  output gdc_cmd_t      drive
);

  localparam int CW = $clog2(DEAD_CYC + 1);

  logic [CW-1:0] gap_r;
  gdc_cmd_t      drive_r;

  assign drive = drive_r;

  // ------------------------------------------------------------
  // Command gating
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= '0;
      gap_r   <= '0;
    end else if (!enable) begin
      drive_r <= '0;
      gap_r   <= CW'(DEAD_CYC);
    end else if (drive_r.hi && (!want.hi || want.lo)) begin
      drive_r.hi <= 1'b0;
      gap_r      <= CW'(DEAD_CYC);
    end else if (drive_r.lo && (!want.lo || want.hi)) begin
      drive_r.lo <= 1'b0;
      gap_r      <= CW'(DEAD_CYC);
    end else if (gap_r != '0) begin
      gap_r <= gap_r - 1'b1;
    end else if (!drive_r.hi && !drive_r.lo) begin
      if (want.hi && !want.lo) begin
        drive_r.hi <= 1'b1;
      end else if (want.lo && !want.hi) begin
        drive_r.lo <= 1'b1;
      end
    end
  end

endmodule

/* logic/gdc_ctrl.sv */
`timescale 1ns/10ps
`include "gdc_map.svh"

// Overview of operation
// - Controller drops all commands on fault
// - Controller waits two seconds before restart
// - Shutdown low and high last 3 us or more
// - V-phase sense routed to U or W input
// - Controller inserts dead time itself
module gdc_ctrl
  import gdc_pkg::*;
#(
  parameter int RESTART_CYC = `GDC_RESTART_CYC,
  parameter int SHDN_CYC    = `GDC_SHDN_CYC,
  parameter int SETTLE_CYC  = `GDC_SETTLE_CYC,
  parameter int DEAD_CYC    = `GDC_DEAD_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] user_high_cmd,
  input  wire logic [2:0] user_low_cmd,
  input  wire logic       user_enable,
  input  wire logic       user_shutdown,
  input  wire logic       fault_line_in,
  output logic            fault_line_out,
  output logic            fault_line_oe,
  output logic [2:0]      ctrl_high_side_out,
  output logic [2:0]      ctrl_low_side_out,
  output logic            fault_seen,
  output logic            running
);

  localparam int RW = $clog2(RESTART_CYC + 1);
  localparam int SW = $clog2(SHDN_CYC + SETTLE_CYC + 1);

  // ------------------------------------------------------------
  // Reset and pin synchronisers
  // ------------------------------------------------------------
  logic       rst_meta_r;
  logic       rst_n_r;
  logic       flt_meta_r;
  logic       flt_sync_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      flt_meta_r <= 1'b1;
      flt_sync_r <= 1'b1;
    end else begin
      flt_meta_r <= fault_line_in;
      flt_sync_r <= flt_meta_r;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  gdc_state_t    state_r;
  gdc_state_t    state_nxt;
  logic [RW-1:0] wait_r;
  logic [SW-1:0] shdn_r;
  logic          drv_low_r;
  logic [2:0]    drv_hist_r;
  logic          fault_low;

  // V sense shares the U/W input on the board
  // Own pulldown is masked until the synchronised line has caught up,
  // so a self-issued shutdown is never read as a fault
  assign fault_low = !flt_sync_r && !drv_low_r && (drv_hist_r == 3'h0);

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      drv_hist_r <= 3'h0;
    end else begin
      drv_hist_r <= {drv_hist_r[1:0], drv_low_r};
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      GDC_RUN: begin
        if (fault_low) begin
          state_nxt = GDC_TRIPPED;
        end else if (user_shutdown) begin
          state_nxt = GDC_SHDN;
        end
      end
      GDC_TRIPPED: begin
        if (flt_sync_r) begin
          state_nxt = GDC_WAIT;
        end
      end
      GDC_WAIT: begin
        if (fault_low) begin
          state_nxt = GDC_TRIPPED;
        end else if (wait_r == '0) begin
          state_nxt = GDC_RUN;
        end
      end
      GDC_SHDN: begin
        if (shdn_r == '0 && !drv_low_r) begin
          state_nxt = GDC_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= GDC_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wait_r <= RW'(RESTART_CYC);
    end else if (state_r != GDC_WAIT || fault_low) begin
      wait_r <= RW'(RESTART_CYC);
    end else if (wait_r != '0) begin
      wait_r <= wait_r - 1'b1;
    end
  end

  // Shutdown pulse low then high, each 3 us or more
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      shdn_r    <= '0;
      drv_low_r <= 1'b0;
    end else if (state_r == GDC_RUN && state_nxt == GDC_SHDN) begin
      shdn_r    <= SW'(SHDN_CYC);
      drv_low_r <= 1'b1;
    end else if (state_r == GDC_SHDN && shdn_r == '0 && drv_low_r) begin
      drv_low_r <= 1'b0;
      shdn_r    <= SW'(SHDN_CYC + SETTLE_CYC);
    end else if (shdn_r != '0) begin
      shdn_r <= shdn_r - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Commands to the device
  // ------------------------------------------------------------
  logic     phase_en;
  gdc_cmd_t drive [3];

  // Commands drop as soon as fault seen
  assign phase_en = (state_r == GDC_RUN) && !fault_low && user_enable;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      gdc_dead_time #(
        .DEAD_CYC (DEAD_CYC)
      ) u_dt (
        .clk    (clk),
        .rst_n  (rst_n_r),
        .enable (phase_en),
        .want   ('{hi: user_high_cmd[g], lo: user_low_cmd[g]}),
        .drive  (drive[g])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_high_side_out <= '0;
      ctrl_low_side_out  <= '0;
      fault_line_out     <= 1'b0;
      fault_line_oe      <= 1'b0;
      fault_seen         <= 1'b0;
      running            <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ctrl_high_side_out[i] <= drive[i].hi && phase_en;
        ctrl_low_side_out[i]  <= drive[i].lo && phase_en;
      end
      fault_line_out <= 1'b0;
      fault_line_oe  <= drv_low_r;
      fault_seen     <= (state_r == GDC_TRIPPED) || fault_low;
      running        <= phase_en;
    end
  end

endmodule

/* dv/gdc_ctrl_asserts.sv */
`timescale 1ns/10ps
// ------------
// Port checks
// ------------
module gdc_chk #(
  parameter int RESTART_CYC = 50,
  parameter int SHDN_CYC    = 4,
  parameter int DEAD_CYC    = 3
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       fault_line_in,
  input wire logic       fault_line_oe,
  input wire logic [2:0] ctrl_high_side_out,
  input wire logic [2:0] ctrl_low_side_out,
  input wire logic       running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [2:0] on_v = ctrl_high_side_out | ctrl_low_side_out;
  int              up_r, oe_r, idle_r;
  int              gap_r [3];
  // Run lengths saturate so long idle spans never wrap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_r   <= 0;
      oe_r   <= 0;
      idle_r <= 0;
      gap_r  <= '{0, 0, 0};
    end else begin
      up_r   <= fault_line_in ? up_r + (up_r < RESTART_CYC) : 0;
      oe_r   <= fault_line_oe ? oe_r + (oe_r < SHDN_CYC) : 0;
      idle_r <= fault_line_oe ? 0 : idle_r + (idle_r < SHDN_CYC);
      for (int i = 0; i < 3; i++) begin
        gap_r[i] <= on_v[i] ? 0 : gap_r[i] + (gap_r[i] < DEAD_CYC);
      end
    end
  end
  sequence s_quiet;
    ctrl_high_side_out == 3'h0 && ctrl_low_side_out == 3'h0;
  endsequence
  sequence s_line_low;
    !fault_line_in [*6];
  endsequence
  AST_DROP_FAST: assert property ($fell(fault_line_in) |-> ##[1:5] s_quiet)
    else $error("Commands kept after fault");
  AST_STAY_DOWN: assert property (s_line_low |-> s_quiet)
    else $error("Command while fault line low");
  AST_RESTART: assert property ($rose(running) |-> up_r >= RESTART_CYC)
    else $error("Restart too early");
  AST_SHDN_LOW: assert property ($fell(fault_line_oe) |-> oe_r >= SHDN_CYC)
    else $error("Shutdown low too short");
  AST_SHDN_HIGH: assert property ($rose(fault_line_oe) |-> idle_r >= SHDN_CYC)
    else $error("Shutdown high too short");
  AST_NO_OVERLAP: assert property (!(|(ctrl_high_side_out & ctrl_low_side_out)))
    else $error("Both sides commanded");
  for (genvar i = 0; i < 3; i++) begin : g_ph
    AST_DEAD: assert property (($rose(ctrl_high_side_out[i]) ||
      $rose(ctrl_low_side_out[i])) |-> gap_r[i] >= DEAD_CYC)
      else $error("Dead time too short");
  end
endmodule
bind gdc_ctrl gdc_chk #(.RESTART_CYC(RESTART_CYC), .SHDN_CYC(SHDN_CYC), .DEAD_CYC(DEAD_CYC))
  chk_u (.clk(clk), .resetn(resetn), .fault_line_in(fault_line_in),
  .fault_line_oe(fault_line_oe), .ctrl_high_side_out(ctrl_high_side_out),
  .ctrl_low_side_out(ctrl_low_side_out), .running(running));

/* dv/gdc_dev.sv */
`timescale 1ns/10ps
// -------------
// Driver model
// -------------
module gdc_dev #(
  parameter int HOLD  = 40,
  parameter int BLANK = 1
) (
  input  wire logic       clk,
  input  wire logic [2:0] hi,
  input  wire logic [2:0] lo,
  input  wire logic       ext_oe,
  input  wire logic       oc,
  output logic            line,
  output logic [2:0]      hg,
  output logic [2:0]      lg
);
  int   hold_r, both_r, sense_r;
  logic trip_r = 1'b0;
  // one sense input also carries V current
  // supplies assumed good, V filter folded into net
  always_ff @(posedge clk) begin
    sense_r <= oc ? sense_r + 1 : 0;
    trip_r  <= (sense_r >= BLANK);
    hold_r <= trip_r ? HOLD : (hold_r > 0 ? hold_r - 1 : 0);
    both_r <= |(hi & lo) ? both_r + 1 : 0;
  end
  assign line = !(hold_r > 0 || both_r >= 80 || ext_oe);
  assign hg = line ? hi : 3'h0;
  assign lg = line ? lo : 3'h0;
endmodule

/* dv/tb_gdc_ctrl.sv */
`timescale 1ns/10ps
// ----------
// Testbench
// ----------
module tb_gdc_ctrl;
  logic       clk, resetn, en, sd, oc, line, run, seen, oe, fout;
  logic [2:0] uh, ul, hi, lo, hg, lg;
  logic [7:0] q [$];
  int         num_errors, check_count;
  event       look;
  gdc_ctrl #(.RESTART_CYC(50), .SHDN_CYC(4), .SETTLE_CYC(2), .DEAD_CYC(3)) dut_u (
    .clk(clk), .resetn(resetn), .user_high_cmd(uh), .user_low_cmd(ul),
    .user_enable(en), .user_shutdown(sd), .fault_line_in(line),
    .fault_line_out(fout), .fault_line_oe(oe), .ctrl_high_side_out(hi),
    .ctrl_low_side_out(lo), .fault_seen(seen), .running(run));
  gdc_dev dev_u (.clk(clk), .hi(hi), .lo(lo), .ext_oe(oe), .oc(oc), .line(line),
    .hg(hg), .lg(lg));
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic note(input int n, input logic [7:0] e);
    repeat (n) @(negedge clk);
    q.push_back(e);
    ->look;
  endtask
  // Bounded wait, a hang counts as a failure
  task automatic wait_run();
    int k;
    for (k = 0; k < 200 && run !== 1'b1; k++) @(negedge clk);
    if (k == 200) begin
      num_errors++;
      wrap_up();
    end
  endtask
  always @(look) check({run, seen, hi, lo}, q.pop_front());
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    logic [2:0] h, l;
    void'($urandom(32'h342D));
    {resetn, en, sd, oc, uh, ul} = '0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    en = 1'b1;
    uh = 3'h7;
    note(20, 8'h00);
    wait_run();
    for (int i = 0; i < 12; i++) begin
      h = 3'($urandom);
      l = 3'($urandom);
      uh = h;
      ul = l;
      note(8, {2'b10, h & ~l, l & ~h});
    end
    uh = 3'h5;
    ul = 3'h2;
    note(8, 8'hAA);
    oc = 1'b1;
    @(negedge clk);
    oc = 0;
    note(6, 8'h40);
    wait_run();
    note(8, 8'hAA);
    sd = 1'b1;
    @(negedge clk);
    sd = 1'b0;
    note(3, 8'h00);
    check({2'b00, hg, lg}, 8'h00);
    wait_run();
    note(8, 8'hAA);
    @(negedge clk);
    wrap_up();
  end
endmodule
